// >>> rtl/host_port_pkg.sv
// constants for the parallel host port pin block
// assumes a single 20 MHz core clock and synchronous active-high reset
// Summary of operation
// RULE_01 - host mode, strobe idle: all eight data lines float
// RULE_02 - strobe active: drive data on read, accept host data on write
// RULE_03 - acknowledge during own service request also drives data lines
// RULE_04 - port not selected: fifteen pins are individual general-purpose lines
// RULE_05 - after reset every shared pin is a general-purpose input
// RULE_06 - three host address inputs select the targeted host register
// RULE_07 - host holds direction steady while strobe is active
// RULE_08 - active-low strobe qualifies transfers; write data taken at rising edge
// RULE_09 - host builds strobe from decoded chip select and enable
// RULE_10 - service request leaves through an open-drain output
// RULE_11 - acknowledge serves DMA handshake and interrupt acknowledge
// RULE_12 - unused request and acknowledge lines held high
// RULE_13 - request pin as general-purpose line is a driven output; here its direction follows gpio_dir_in like the other pins
// RULE_14 - reset-cleared mode bit picks host or gpio; per-pin direction and value
package host_port_pkg;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned PIN_N     = 15;
  localparam int unsigned POS_ADDR  = 8;
  localparam int unsigned POS_DIR   = 11;
  localparam int unsigned POS_STB   = 12;
  localparam int unsigned POS_REQ   = 13;
  localparam int unsigned POS_ACK   = 14;
  localparam logic [PIN_N-1:0] GPIO_DIR_RESET = 15'h0000;
  localparam logic [PIN_N-1:0] GPIO_OUT_RESET = 15'h0000;
  localparam logic [PIN_N-1:0] PIN_RESET      = 15'h7fff;
  typedef enum logic [1:0] {
    XFER_IDLE  = 2'b00,
    XFER_READ  = 2'b01,
    XFER_WRITE = 2'b10
  } xfer_state_t;
endpackage : host_port_pkg

// >>> rtl/pin_sync.sv
// two-flop synchroniser bank for pin inputs
// assumes inputs asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 15,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync needs a width of at least one");
  end
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end
  assign sync_out = sync_reg;
endmodule : pin_sync
`default_nettype wire

// >>> rtl/parallel_host_port.sv
// pin-level parallel host port sharing fifteen pins with general-purpose i/o
// assumes core logic supplies read data and consumes write strobes on core_clk
`timescale 1ns/1ps
`default_nettype none
module parallel_host_port
  import host_port_pkg::*;
(
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  input  wire logic                               host_mode_sel,
  input  wire logic [host_port_pkg::PIN_N-1:0]    gpio_dir_in,
  input  wire logic [host_port_pkg::PIN_N-1:0]    gpio_value_in,
  output logic      [host_port_pkg::PIN_N-1:0]    gpio_level,
  input  wire logic [host_port_pkg::PIN_N-1:0]    pin_i,
  output logic      [host_port_pkg::PIN_N-1:0]    pin_o,
  output logic      [host_port_pkg::PIN_N-1:0]    pin_oe_n,
  input  wire logic [host_port_pkg::DATA_W-1:0]   read_data,
  input  wire logic                               service_request,
  output logic      [host_port_pkg::ADDR_W-1:0]   host_reg_select,
  output logic      [host_port_pkg::DATA_W-1:0]   write_data,
  output logic                                    write_strobe,
  output logic                                    read_strobe,
  output logic                                    ack_strobe
);
  import host_port_pkg::*;

  logic [PIN_N-1:0] pins_s;
  pin_sync #(.WIDTH(PIN_N), .INIT(PIN_RESET)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (pin_i),
    .sync_out (pins_s)
  );

  logic              mode_reg, mode_next;
  logic [PIN_N-1:0]  dir_reg, dir_next;
  logic [PIN_N-1:0]  val_reg, val_next;
  logic [PIN_N-1:0]  lvl_reg, lvl_next;
  logic [DATA_W-1:0] rd_reg, rd_next;
  logic [DATA_W-1:0] wd_reg, wd_next;
  logic [ADDR_W-1:0] sel_reg, sel_next;
  logic              req_reg, req_next;
  logic              ack_d_reg, ack_d_next;
  logic              wstb_reg, wstb_next;
  logic              rstb_reg, rstb_next;
  logic              astb_reg, astb_next;
  xfer_state_t       st_reg, st_next;

  logic strobe_act, dir_rd, ack_act;
  assign strobe_act = mode_reg & ~pins_s[POS_STB];             // [RULE_08]
  assign dir_rd     = pins_s[POS_DIR];
  assign ack_act    = mode_reg & ~pins_s[POS_ACK];             // [RULE_11]

  always_comb begin
    mode_next  = host_mode_sel;                                // [RULE_14]
    dir_next   = gpio_dir_in;
    val_next   = gpio_value_in;
    lvl_next   = pins_s;
    rd_next    = read_data;
    req_next   = mode_reg & service_request;
    sel_next   = sel_reg;
    wd_next    = wd_reg;
    st_next    = st_reg;
    wstb_next  = 1'b0;
    rstb_next  = 1'b0;
    ack_d_next = ack_act;
    astb_next  = ack_act & ~ack_d_reg & req_reg;               // [RULE_11]
    unique case (st_reg)
      XFER_IDLE: begin
        if (strobe_act) begin
          sel_next = pins_s[POS_ADDR +: ADDR_W];               // [RULE_06]
          st_next  = dir_rd ? XFER_READ : XFER_WRITE;          // [RULE_07]
          rstb_next = dir_rd;
        end
      end
      XFER_READ: begin
        if (!strobe_act) st_next = XFER_IDLE;
      end
      XFER_WRITE: begin
        wd_next = pins_s[DATA_W-1:0];
        if (!strobe_act) begin
          st_next   = XFER_IDLE;                               // [RULE_08]
          wstb_next = 1'b1;
        end
      end
      default: st_next = XFER_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg  <= 1'b0;                                       // [RULE_05]
      dir_reg   <= GPIO_DIR_RESET;
      val_reg   <= GPIO_OUT_RESET;
      lvl_reg   <= PIN_RESET;
      rd_reg    <= '0;
      wd_reg    <= '0;
      sel_reg   <= '0;
      req_reg   <= 1'b0;
      ack_d_reg <= 1'b0;
      wstb_reg  <= 1'b0;
      rstb_reg  <= 1'b0;
      astb_reg  <= 1'b0;
      st_reg    <= XFER_IDLE;
    end else begin
      mode_reg  <= mode_next;
      dir_reg   <= dir_next;
      val_reg   <= val_next;
      lvl_reg   <= lvl_next;
      rd_reg    <= rd_next;
      wd_reg    <= wd_next;
      sel_reg   <= sel_next;
      req_reg   <= req_next;
      ack_d_reg <= ack_d_next;
      wstb_reg  <= wstb_next;
      rstb_reg  <= rstb_next;
      astb_reg  <= astb_next;
      st_reg    <= st_next;
    end
  end

  logic data_drive;
  assign data_drive = mode_reg &
                      ((strobe_act & dir_rd) |                 // [RULE_02]
                       (ack_act & req_reg));                   // [RULE_03]

  always_comb begin
    if (!mode_reg) begin
      pin_o    = val_reg;                                      // [RULE_04]
      pin_oe_n = ~dir_reg;                                     // [RULE_13]
    end else begin
      pin_o    = '0;
      pin_oe_n = '1;
      pin_o[DATA_W-1:0]    = rd_reg;
      pin_oe_n[DATA_W-1:0] = {DATA_W{~data_drive}};            // [RULE_01]
      pin_oe_n[POS_REQ]    = ~req_reg;                         // [RULE_10]
    end
  end

  assign gpio_level      = lvl_reg;
  assign host_reg_select = sel_reg;
  assign write_data      = wd_reg;
  assign write_strobe    = wstb_reg;
  assign read_strobe     = rstb_reg;
  assign ack_strobe      = astb_reg;

  property p_idle_float;
    @(posedge core_clk) disable iff (rst)
      (mode_reg && !strobe_act && !(ack_act && req_reg)) |-> (&pin_oe_n[DATA_W-1:0]);
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("data driven while idle"); // [RULE_01]

  property p_read_drive;
    @(posedge core_clk) disable iff (rst)
      (mode_reg && strobe_act && dir_rd) |-> (pin_oe_n[DATA_W-1:0] == '0);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven"); // [RULE_02]

  property p_write_float;
    @(posedge core_clk) disable iff (rst)
      (mode_reg && strobe_act && !dir_rd && !(ack_act && req_reg))
        |-> (&pin_oe_n[DATA_W-1:0]);
  endproperty
  a_write_float: assert property (p_write_float) else $error("write drove bus"); // [RULE_02]

  property p_ack_drive;
    @(posedge core_clk) disable iff (rst)
      (ack_act && req_reg) |-> (pin_oe_n[DATA_W-1:0] == '0);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driving"); // [RULE_03]

  property p_gpio_map;
    @(posedge core_clk) disable iff (rst)
      !mode_reg |-> (pin_oe_n == ~dir_reg && pin_o == val_reg);
  endproperty
  a_gpio_map: assert property (p_gpio_map) else $error("gpio mapping wrong"); // [RULE_04]

  property p_reset_input;
    @(posedge core_clk) disable iff (rst)
      $past(rst) |-> (&pin_oe_n);
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pin driven after reset"); // [RULE_05]

  property p_write_capture;
    @(posedge core_clk) disable iff (rst)
      (st_reg == XFER_WRITE && !strobe_act)
        |=> (write_strobe && write_data == $past(pins_s[DATA_W-1:0]));
  endproperty
  a_write_capture: assert property (p_write_capture) else $error("write data lost"); // [RULE_08]

  property p_req_od;
    @(posedge core_clk) disable iff (rst)
      mode_reg |-> (pin_o[POS_REQ] == 1'b0 && pin_oe_n[POS_REQ] == !req_reg);
  endproperty
  a_req_od: assert property (p_req_od) else $error("request not open-drain"); // [RULE_10]

  property p_addr_latch;
    @(posedge core_clk) disable iff (rst)
      (st_reg == XFER_IDLE && strobe_act) |=> (host_reg_select == $past(pins_s[POS_ADDR +: ADDR_W]));
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched"); // [RULE_06]

  // read access announced one cycle after the strobe is seen
  property p_read_strobe;
    @(posedge core_clk) disable iff (rst)
      (st_reg == XFER_IDLE && strobe_act && dir_rd) |=> read_strobe;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe missing"); // [RULE_02]

  // acknowledge pulse only while own request was up
  property p_ack_strobe;
    @(posedge core_clk) disable iff (rst)
      ack_strobe |-> $past(req_reg);
  endproperty
  a_ack_strobe: assert property (p_ack_strobe) else $error("ack without request"); // [RULE_11]

  // first edge after reset: gpio mode, no strobes
  property p_reset_state;
    @(posedge core_clk) disable iff (rst)
      $past(rst) |-> (!mode_reg && !write_strobe && !read_strobe && !ack_strobe);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state not reset"); // [RULE_05]

  c_read:  cover property (@(posedge core_clk) disable iff (rst) read_strobe);
  c_write: cover property (@(posedge core_clk) disable iff (rst) write_strobe);
  c_ack:   cover property (@(posedge core_clk) disable iff (rst) ack_strobe);
  c_gpio:  cover property (@(posedge core_clk) disable iff (rst) !mode_reg && !pin_oe_n[POS_REQ]);
  c_req:   cover property (@(posedge core_clk) disable iff (rst) mode_reg && !pin_oe_n[POS_REQ]);
endmodule : parallel_host_port
`default_nettype wire

// >>> tb/host_model.sv
// host-side model of the shared pins, driven through tasks from the bench
// assumes the bench calls its tasks; every pin resolves against device enables
`timescale 1ns/1ps
`default_nettype none
module host_model
  import host_port_pkg::*;
(
  input  wire logic [host_port_pkg::PIN_N-1:0] pin_o,
  input  wire logic [host_port_pkg::PIN_N-1:0] pin_oe_n,
  input  wire logic                            core_clk,
  output logic      [host_port_pkg::PIN_N-1:0] pin_i
);
  logic [PIN_N-1:0] drv_en  = '0;
  logic [PIN_N-1:0] drv_val = '0;
  logic             cs      = 1'b0;
  logic             en      = 1'b0;
  // wire level: device, then host, then pull-up or a moving level
  always_comb begin
    for (int k = 0; k < PIN_N; k++) begin
      if (!pin_oe_n[k]) pin_i[k] = pin_o[k];
      else if (drv_en[k]) pin_i[k] = drv_val[k];
      else if (k >= POS_STB) pin_i[k] = 1'b1;
      else pin_i[k] = ~drv_val[k];
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // one byte access; oe_mid is the data enable seen mid-strobe
  task automatic xfer(input logic rd, input logic [2:0] addr, input logic [7:0] wd,
                      output logic [7:0] rdata, output logic [7:0] oe_mid);
    step(1);
    drv_val[10:8] = addr;
    drv_val[11]   = rd;
    drv_val[7:0]  = wd;
    drv_en[12:8]  = 5'h1f;
    drv_en[7:0]   = {8{!rd}};
    cs            = 1'b1;
    en            = 1'b1;
    drv_val[12]   = ~(cs & en);
    step(5);
    rdata  = pin_i[7:0];
    oe_mid = pin_oe_n[7:0];
    en          = 1'b0;
    drv_val[12] = ~(cs & en); // direction still held
    step(3);
    drv_en = '0;
    cs     = 1'b0;
    step(4);
  endtask : xfer
  task automatic ack(output logic [7:0] rdata, output logic [7:0] oe_mid);
    step(1);
    drv_en[14]  = 1'b1;
    drv_val[14] = 1'b0;
    step(4);
    rdata  = pin_i[7:0];
    oe_mid = pin_oe_n[7:0];
    drv_en[14] = 1'b0;
    step(5);
  endtask : ack
endmodule : host_model
`default_nettype wire

// >>> tb/parallel_host_port_tb.sv
// self-checking bench for the parallel host port pin block
// assumes host_model on the pins; inputs move 1 ns after core_clk rises
`timescale 1ns/1ps
`default_nettype none
module parallel_host_port_tb;
  import host_port_pkg::*;
  logic core_clk = 0;
  logic rst, host_mode_sel, service_request;
  logic [PIN_N-1:0]  gpio_dir_in, gpio_value_in, gpio_level, pin_i, pin_o, pin_oe_n;
  logic [DATA_W-1:0] read_data, write_data, rd, oe;
  logic [ADDR_W-1:0] host_reg_select;
  logic              write_strobe, read_strobe, ack_strobe;
  int num_errors = 0, n_compared = 0, n_wr = 0, n_rd = 0, n_ack = 0;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (write_strobe === 1'b1) n_wr++;
    if (read_strobe === 1'b1) n_rd++;
    if (ack_strobe === 1'b1) n_ack++;
  end
  parallel_host_port uut (.core_clk, .rst, .host_mode_sel, .gpio_dir_in, .gpio_value_in,
    .gpio_level, .pin_i, .pin_o, .pin_oe_n, .read_data, .service_request,
    .host_reg_select, .write_data, .write_strobe, .read_strobe, .ack_strobe);
  host_model host (.pin_o, .pin_oe_n, .core_clk, .pin_i);
  task automatic chk(input string nm, input logic [14:0] exp, input logic [14:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic results;
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic t_gpio;
    gpio_dir_in   = 15'h2a0f;
    gpio_value_in = 15'h2005;
    host.drv_en   = 15'h55f0;
    host.drv_val  = 15'h1450;
    host.step(6);
    chk("gpio oe_n", ~15'h2a0f, pin_oe_n);
    chk("gpio out", 15'h2005, pin_o & 15'h2a0f);
    chk("gpio request pin", 15'h1, {14'h0, pin_o[13]});
    chk("gpio level", 15'h3455, gpio_level);
    host.drv_en = '0;
    gpio_dir_in = '0;
    host_mode_sel = 1'b1;
    host.step(4);
    chk("idle data oe_n", 15'h00ff, {7'h0, pin_oe_n[7:0]});
  endtask : t_gpio
  task automatic t_access(input logic r, input logic [2:0] a, input logic [7:0] d);
    int wr0, rd0;
    wr0 = n_wr;
    rd0 = n_rd;
    read_data = d;
    host.xfer(r, a, d, rd, oe);
    chk("data oe_n mid", r ? 15'h0 : 15'hff, {7'h0, oe});
    chk("reg select", {12'h0, a}, {12'h0, host_reg_select});
    chk("strobe count", 15'h1, r ? 15'(n_rd - rd0) : 15'(n_wr - wr0));
    chk("data", {7'h0, d}, {7'h0, r ? rd : write_data});
    chk("after data oe_n", 15'hff, {7'h0, pin_oe_n[7:0]});
  endtask : t_access
  task automatic t_req_ack;
    service_request = 1'b1;
    read_data = 8'h96;
    host.step(2);
    chk("request pin", 15'h0, {13'h0, pin_oe_n[13], pin_o[13]});
    host.ack(rd, oe);
    chk("ack data oe_n", 15'h0, {7'h0, oe});
    chk("ack data", 15'h96, {7'h0, rd});
    chk("ack count", 15'h1, 15'(n_ack));
    service_request = 1'b0;
    host.step(2);
    chk("request released", 15'h1, {14'h0, pin_oe_n[13]});
    host.ack(rd, oe);
    chk("ack no request oe_n", 15'hff, {7'h0, oe});
    chk("ack no request count", 15'h1, 15'(n_ack));
  endtask : t_req_ack
  // reset in mid-run from host mode with the request pin pulled low
  task automatic t_reset;
    service_request = 1'b1;
    host.step(2);
    rst           = 1'b1;
    host_mode_sel = 1'b0;
    host.step(3);
    chk("mid reset oe_n", PIN_RESET, pin_oe_n);
    rst             = 1'b0;
    service_request = 1'b0;
    host.step(2);
    chk("after mid reset oe_n", PIN_RESET, pin_oe_n);
    chk("after mid reset level", PIN_RESET, gpio_level);
  endtask : t_reset
  initial begin
    rst             = 1'b1;
    host_mode_sel   = 1'b0;
    service_request = 1'b0;
    gpio_dir_in     = '0;
    gpio_value_in   = '0;
    read_data       = '0;
    host.step(16);
    chk("reset oe_n", PIN_RESET, pin_oe_n);
    rst = 1'b0;
    host.step(2);
    chk("post reset oe_n", PIN_RESET, pin_oe_n);
    t_gpio();
    t_access(1'b0, 3'h0, 8'ha7);
    t_access(1'b1, 3'h7, 8'h3c);
    t_access(1'b0, 3'h5, 8'h5a);
    t_access(1'b1, 3'h2, 8'hc3);
    t_req_ack();
    t_reset();
    results();
  end
  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule : parallel_host_port_tb
`default_nettype wire
